/* File: hw/cbt_defines.svh */
// Timing constants, field widths and reset values of the bit timing block.
`ifndef CBT_DEFINES_SVH
`define CBT_DEFINES_SVH
`define CBT_PRESCALER_W 6
`define CBT_SEG_FIELD_W 3
`define CBT_JUMP_FIELD_W 2
`define CBT_COUNT_W 4
`define CBT_ERROR_W 5
`define CBT_IPT_TQ 4'h2
`define CBT_RECESSIVE 1'b1
`define CBT_RX_RESET 1'b1
`define CBT_COUNT_RESET 4'h0
`define CBT_ADJUST_RESET 3'h0
`define CBT_PRESC_RESET 6'h00
`endif

/* File: hw/cbt_pkg.sv */
// Types shared by the bit timing block and its quantum prescaler.
`include "cbt_defines.svh"
package cbt_pkg;
  typedef enum logic [1:0] {
    SEG_SYNC = 2'h0,
    SEG_PROP = 2'h1,
    SEG_PH1 = 2'h3,
    SEG_PH2 = 2'h2
  } cbt_seg_type;

  typedef struct packed {
    logic [`CBT_PRESCALER_W-1:0] cnt;
    logic phase;
  } cbt_presc_state_type;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic rx_prev;
    cbt_seg_type seg;
    logic [`CBT_COUNT_W-1:0] cnt;
    logic [2:0] ext;
    logic [2:0] shorten;
    logic synced;
    logic [1:0] samp;
    logic rx_bit;
    logic sample_pulse;
    logic bit_start;
    logic hard_pulse;
    logic resync_pulse;
  } cbt_timer_state_type;
endpackage

/* File: hw/cbt_tick_if.sv */
// Quantum tick signals between the prescaler and the bit timer.
`timescale 1ns/1ns
`default_nettype none
interface cbt_tick_if;
  logic restart;
  logic half_tick;
  logic tq_tick;
  modport source(input restart, output half_tick, output tq_tick);
  modport timer(output restart, input half_tick, input tq_tick);
endinterface
`default_nettype wire

/* File: hw/cbt_quantum_prescaler.sv */
// Divides the clock into half quanta and time quanta.
`timescale 1ns/1ns
`default_nettype none
`include "cbt_defines.svh"
module cbt_quantum_prescaler (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Configuration.
  input wire logic [`CBT_PRESCALER_W-1:0] quantum_prescaler,
  // Tick carrier.
  cbt_tick_if.source tick
);
  import cbt_pkg::*;

  cbt_presc_state_type st_q;
  cbt_presc_state_type st_d;
  logic wrap;

  // A half quantum is prescaler plus one clocks, so a quantum is twice that.
  assign wrap = (st_q.cnt == quantum_prescaler);
  assign tick.half_tick = wrap;
  assign tick.tq_tick = wrap & st_q.phase;

  always_comb begin
    st_d = st_q;
    if (tick.restart) begin
      st_d.cnt = `CBT_PRESC_RESET;
      st_d.phase = 1'b0;
    end else if (wrap) begin
      st_d.cnt = `CBT_PRESC_RESET;
      st_d.phase = ~st_q.phase;
    end else begin
      st_d.cnt = st_q.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  chk_quantum_two_halves: assert property (@(posedge clk) disable iff (!reset_n)
    (tick.tq_tick && !tick.restart) |=> !tick.tq_tick) else $error("quantum shorter than two halves");
  chk_half_tick_count: assert property (@(posedge clk) disable iff (!reset_n)
    tick.half_tick |-> st_q.cnt == quantum_prescaler) else $error("half tick off count");
endmodule
`default_nettype wire

/* File: hw/cbt_bit_timing.sv */
// Bit timing, sampling and synchronization logic of the bus controller.
//
// Overview of operation
// - A quantum lasts two times prescaler plus one oscillator clocks.
// - Total bit lengths of 5 to 25 quanta are accepted; use 8 or more.
// - Every bit opens with a synchronization segment exactly one quantum long.
// - Propagation segment is field plus one, 1 to 8 quanta.
// - Phase one is 1 to 8 quanta and may be lengthened by resynchronization.
// - Phase two field gives 1 to 8 quanta, but the length is never set below 2 quanta.
// - In automatic mode phase two equals larger of phase one and processing time.
// - Source select high takes phase two from its field, low uses automatic rule.
// - The received bit is decided at the end of phase one.
// - Triple sampling takes majority of samples at half quantum spacing.
// - Sample count select high picks triple sampling, low a single sample.
// - Two quanta after the sample point are kept for processing.
// - Hard synchronization only on a falling edge while the bus is idle.
// - Hard synchronization restarts the bit at the synchronization segment.
// - At most one synchronization in each bit time.
// - Jump width of 1 to 4 quanta bounds every resynchronization.
// - Only recessive to dominant edges are used for synchronization.
// - Phase error is zero in sync, positive before, negative after sample point.
// - Phase error within jump width resynchronizes like a hard synchronization.
// - Positive error beyond jump width lengthens phase one by the jump width.
// - Negative error beyond jump width shortens phase two by the jump width.
// - An edge counts only if the last sampled bit differs from the new level.
// - No resynchronization on positive error while sending a dominant bit.
`timescale 1ns/1ns
`default_nettype none
`include "cbt_defines.svh"
module cbt_bit_timing (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Timing configuration.
  input wire logic [`CBT_PRESCALER_W-1:0] quantum_prescaler,
  input wire logic [`CBT_SEG_FIELD_W-1:0] propagation_length,
  input wire logic [`CBT_SEG_FIELD_W-1:0] phase_one_length,
  input wire logic [`CBT_SEG_FIELD_W-1:0] phase_two_length,
  input wire logic phase_two_source_select,
  input wire logic sample_count_select,
  input wire logic [`CBT_JUMP_FIELD_W-1:0] jump_width,
  // Bus side.
  input wire logic bus_receive_pin,
  // Frame logic status.
  input wire logic bus_idle,
  input wire logic transmitting_dominant,
  // Timing results.
  output var logic rx_bit,
  output var logic sample_point,
  output var logic bit_start,
  output var logic hard_sync,
  output var logic resync,
  output var cbt_pkg::cbt_seg_type segment
);
  import cbt_pkg::*;

  cbt_timer_state_type st_q;
  cbt_timer_state_type st_d;
  cbt_tick_if tick ();

  logic [`CBT_COUNT_W-1:0] prop_len;
  logic [`CBT_COUNT_W-1:0] ph1_len;
  logic [`CBT_COUNT_W-1:0] ph2_len;
  logic [`CBT_COUNT_W-1:0] ph2_field;
  logic [`CBT_COUNT_W-1:0] ph2_auto;
  logic [`CBT_COUNT_W-1:0] sjw_len;
  logic [`CBT_COUNT_W-1:0] ph1_end;
  logic [`CBT_ERROR_W-1:0] err_mag;
  logic fall_edge;
  logic usable_edge;
  logic majority;
  logic positive;
  logic do_restart;
  logic do_extend;
  logic do_shorten;

  // Field value n selects a length of n plus one quanta.
  function automatic logic [`CBT_COUNT_W-1:0] field_len(input logic [2:0] f);
    field_len = {1'b0, f} + 4'h1;
  endfunction

  cbt_quantum_prescaler u_prescaler (
    .clk(clk),
    .reset_n(reset_n),
    .quantum_prescaler(quantum_prescaler),
    .tick(tick.source)
  );

  assign prop_len = field_len(propagation_length);
  assign ph1_len = field_len(phase_one_length);
  assign sjw_len = field_len({1'b0, jump_width});
  assign ph2_field = field_len(phase_two_length);
  assign ph2_auto = (ph1_len > `CBT_IPT_TQ) ? ph1_len : `CBT_IPT_TQ;

  // Phase two never drops below the processing time.
  always_comb begin
    if (phase_two_source_select) begin
      ph2_len = (ph2_field > `CBT_IPT_TQ) ? ph2_field : `CBT_IPT_TQ;
    end else begin
      ph2_len = ph2_auto;
    end
  end

  assign ph1_end = ph1_len + {1'b0, st_q.ext} - 4'h1;
  assign majority = (st_q.sync2 & st_q.samp[0]) | (st_q.sync2 & st_q.samp[1])
    | (st_q.samp[0] & st_q.samp[1]);
  assign fall_edge = (st_q.rx_prev == `CBT_RECESSIVE) && (st_q.sync2 != `CBT_RECESSIVE);
  assign usable_edge = fall_edge && (st_q.rx_bit != st_q.sync2) && !st_q.synced;

  // Phase error magnitude and sign, in quanta, of an edge in the current segment.
  always_comb begin
    positive = 1'b0;
    err_mag = 5'h00;
    case (st_q.seg)
      SEG_PROP: begin
        positive = 1'b1;
        err_mag = {1'b0, st_q.cnt} + 5'h01;
      end
      SEG_PH1: begin
        positive = 1'b1;
        err_mag = {1'b0, prop_len} + {1'b0, st_q.cnt} + 5'h01;
      end
      SEG_PH2: begin
        err_mag = {1'b0, ph2_len} - {1'b0, st_q.cnt} - {2'b00, st_q.shorten};
      end
      default: begin
        err_mag = 5'h00;
      end
    endcase
  end

  // Decides which synchronization, if any, this edge causes.
  always_comb begin
    do_restart = 1'b0;
    do_extend = 1'b0;
    do_shorten = 1'b0;
    if (usable_edge) begin
      if (bus_idle) begin
        do_restart = 1'b1;
      end else if (st_q.seg != SEG_SYNC) begin
        if (!(positive && transmitting_dominant)) begin
          if (err_mag <= {1'b0, sjw_len}) begin
            do_restart = 1'b1;
          end else if (positive) begin
            do_extend = 1'b1;
          end else begin
            do_shorten = 1'b1;
          end
        end
      end
    end
  end

  assign tick.restart = do_restart;

  always_comb begin
    st_d = st_q;
    st_d.sync1 = bus_receive_pin;
    st_d.sync2 = st_q.sync1;
    st_d.rx_prev = st_q.sync2;
    st_d.sample_pulse = 1'b0;
    st_d.bit_start = 1'b0;
    st_d.hard_pulse = 1'b0;
    st_d.resync_pulse = 1'b0;
    if (tick.half_tick) begin
      st_d.samp = {st_q.samp[0], st_q.sync2};
    end
    if (tick.tq_tick) begin
      case (st_q.seg)
        SEG_SYNC: begin
          st_d.seg = SEG_PROP;
          st_d.cnt = `CBT_COUNT_RESET;
        end
        SEG_PROP: begin
          if (st_q.cnt >= prop_len - 4'h1) begin
            st_d.seg = SEG_PH1;
            st_d.cnt = `CBT_COUNT_RESET;
          end else begin
            st_d.cnt = st_q.cnt + 4'h1;
          end
        end
        SEG_PH1: begin
          if (st_q.cnt >= ph1_end) begin
            st_d.seg = SEG_PH2;
            st_d.cnt = `CBT_COUNT_RESET;
            st_d.sample_pulse = 1'b1;
            st_d.rx_bit = sample_count_select ? majority : st_q.sync2;
          end else begin
            st_d.cnt = st_q.cnt + 4'h1;
          end
        end
        SEG_PH2: begin
          if ({1'b0, st_q.cnt} + 5'h01 + {2'b00, st_q.shorten} >= {1'b0, ph2_len}) begin
            st_d.seg = SEG_SYNC;
            st_d.cnt = `CBT_COUNT_RESET;
            st_d.ext = `CBT_ADJUST_RESET;
            st_d.shorten = `CBT_ADJUST_RESET;
            st_d.synced = 1'b0;
            st_d.bit_start = 1'b1;
          end else begin
            st_d.cnt = st_q.cnt + 4'h1;
          end
        end
        default: begin
          st_d.seg = SEG_SYNC;
          st_d.cnt = `CBT_COUNT_RESET;
        end
      endcase
    end
    if (do_restart) begin
      // A restart on the sample tick wins, so that sample is dropped.
      st_d.sample_pulse = 1'b0;
      st_d.rx_bit = st_q.rx_bit;
      st_d.seg = SEG_SYNC;
      st_d.cnt = `CBT_COUNT_RESET;
      st_d.ext = `CBT_ADJUST_RESET;
      st_d.shorten = `CBT_ADJUST_RESET;
      st_d.synced = 1'b1;
      st_d.bit_start = 1'b1;
      st_d.hard_pulse = bus_idle;
      st_d.resync_pulse = !bus_idle;
    end else if (do_extend) begin
      st_d.ext = sjw_len[2:0];
      st_d.synced = 1'b1;
      st_d.resync_pulse = 1'b1;
    end else if (do_shorten) begin
      st_d.shorten = sjw_len[2:0];
      st_d.synced = 1'b1;
      st_d.resync_pulse = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q.sync1 <= `CBT_RECESSIVE;
      st_q.sync2 <= `CBT_RECESSIVE;
      st_q.rx_prev <= `CBT_RECESSIVE;
      st_q.seg <= SEG_SYNC;
      st_q.cnt <= `CBT_COUNT_RESET;
      st_q.ext <= `CBT_ADJUST_RESET;
      st_q.shorten <= `CBT_ADJUST_RESET;
      st_q.synced <= 1'b0;
      st_q.samp <= 2'h3;
      st_q.rx_bit <= `CBT_RX_RESET;
      st_q.sample_pulse <= 1'b0;
      st_q.bit_start <= 1'b0;
      st_q.hard_pulse <= 1'b0;
      st_q.resync_pulse <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rx_bit = st_q.rx_bit;
  assign sample_point = st_q.sample_pulse;
  assign bit_start = st_q.bit_start;
  assign hard_sync = st_q.hard_pulse;
  assign resync = st_q.resync_pulse;
  assign segment = st_q.seg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_sync_one_quantum: assert property ((st_q.seg == SEG_SYNC && tick.tq_tick && !do_restart)
    |=> st_q.seg == SEG_PROP) else $error("sync segment not one quantum");
  chk_sample_ends_ph1: assert property (st_q.sample_pulse
    |-> $past(st_q.seg) == SEG_PH1 && st_q.seg == SEG_PH2) else $error("sample off phase one end");
  chk_single_sample: assert property ((tick.tq_tick && st_q.seg == SEG_PH1 && !sample_count_select
    && st_q.cnt >= ph1_end && !do_restart) |=> st_q.rx_bit == $past(st_q.sync2))
    else $error("single sample wrong");
  chk_hard_restart: assert property (st_q.hard_pulse
    |-> st_q.seg == SEG_SYNC && st_q.cnt == 4'h0 && $past(bus_idle)) else $error("hard sync bad");
  chk_one_sync_bit: assert property ((st_q.hard_pulse || st_q.resync_pulse)
    |-> st_q.synced && !$past(st_q.synced)) else $error("second sync in bit");
  chk_falling_only: assert property ((st_q.hard_pulse || st_q.resync_pulse)
    |-> $past(st_q.rx_prev) && !$past(st_q.sync2)) else $error("sync on wrong edge");
  chk_no_tx_positive: assert property ((st_q.resync_pulse && $past(transmitting_dominant))
    |-> $past(st_q.seg) == SEG_PH2) else $error("positive resync while sending");
  chk_extend_by_jump: assert property ((do_extend && !tick.tq_tick)
    |=> st_q.ext == $past(sjw_len[2:0])) else $error("phase one not lengthened by jump");
  chk_ph2_floor: assert property (ph2_len >= `CBT_IPT_TQ) else $error("phase two below two quanta");

  // Shortening holds the jump width for the rest of the bit.
  chk_shorten_by_jump: assert property ((do_shorten && !tick.tq_tick)
    |=> st_q.shorten == $past(sjw_len[2:0])) else $error("phase two not shortened by jump");

  // Triple sampling hands over the vote of the three samples.
  chk_triple_vote: assert property ((tick.tq_tick && st_q.seg == SEG_PH1 && sample_count_select
    && st_q.cnt >= ph1_end && !do_restart) |=> st_q.rx_bit == $past(majority))
    else $error("triple sample vote wrong");

  // A restart always reopens the bit in the sync segment.
  chk_restart_to_sync: assert property (do_restart
    |=> st_q.seg == SEG_SYNC && st_q.bit_start && !st_q.sample_pulse)
    else $error("restart did not reopen the bit");
endmodule
`default_nettype wire

/* File: tb/cbt_bus_node.sv */
// Model of another node on the bus, seen through the transceiver.
`timescale 1ns/1ns
`default_nettype none
module cbt_bus_node (
  // Clock.
  input wire logic clk,
  // Frame request.
  input wire logic start,
  input wire logic [7:0] pattern,
  input wire logic [7:0] bit_cycles,
  // Dominant level driven by a further node.
  input wire logic force_dom,
  // Bus level at the receiver.
  output var logic bus_level
);
  logic [7:0] pat_q = 8'hFF;
  int bits_q = 0;
  int cyc_q = 0;
  always_ff @(posedge clk) begin
    if (start) begin
      pat_q <= pattern;
      bits_q <= 8;
      cyc_q <= 0;
    end else if (bits_q != 0) begin
      if (cyc_q == int'(bit_cycles) - 1) begin
        cyc_q <= 0;
        bits_q <= bits_q - 1;
        pat_q <= {1'b1, pat_q[7:1]};
      end else begin
        cyc_q <= cyc_q + 1;
      end
    end
  end
  // A released bus is pulled to the recessive level.
  assign bus_level = ((bits_q != 0) ? pat_q[0] : 1'b1) & ~force_dom;
endmodule
`default_nettype wire

/* File: tb/tb_cbt_bit_timing.sv */
// Self-checking bench for the bit timing block.
`timescale 1ns/1ns
`default_nettype none
module tb_cbt_bit_timing;
  import cbt_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] presc = 6'h00;
  logic [2:0] prop_len = 3'h0;
  logic [2:0] ph1_len = 3'h0;
  logic [2:0] ph2_len = 3'h0;
  logic ph2_src = 1'b0;
  logic samp_sel = 1'b0;
  logic [1:0] jump = 2'h0;
  logic idle = 1'b1;
  logic tx_dom = 1'b0;
  logic other_dom = 1'b0;
  logic start = 1'b0;
  logic pin;
  logic rx_bit;
  logic sample_point;
  logic bit_start;
  logic hard_sync;
  logic resync;
  cbt_seg_type segment;
  logic [4:0] pulses;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  assign pulses = {hard_sync | resync, resync, hard_sync, sample_point, bit_start};
  always #2 clk = ~clk;
  cbt_bit_timing DUT (.clk(clk), .reset_n(reset_n), .quantum_prescaler(presc),
    .propagation_length(prop_len), .phase_one_length(ph1_len), .phase_two_length(ph2_len),
    .phase_two_source_select(ph2_src), .sample_count_select(samp_sel), .jump_width(jump),
    .bus_receive_pin(pin), .bus_idle(idle), .transmitting_dominant(tx_dom),
    .rx_bit(rx_bit), .sample_point(sample_point), .bit_start(bit_start),
    .hard_sync(hard_sync), .resync(resync), .segment(segment));
  cbt_bus_node node (.clk(clk), .start(start), .pattern(8'hAA), .bit_cycles(8'h18),
    .force_dom(other_dom), .bus_level(pin));
  task automatic tally_and_finish;
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Counts edges until the chosen pulse is seen.
  task automatic wait_on(input int k, output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (pulses[k] !== 1'b1 && c < 600);
    if (c >= 600)
      check(16'h0000, 16'h0001);
  endtask
  task automatic count_on(input int k, input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      if (pulses[k] === 1'b1)
        c++;
    end
  endtask
  // Settings keep propagation plus phase one at or above phase two.
  task automatic cfg(input logic [5:0] b, input logic [2:0] p, input logic [2:0] a,
    input logic [2:0] c, input logic s, input logic [1:0] j);
    presc = b;
    prop_len = p;
    ph1_len = a;
    ph2_len = c;
    ph2_src = s;
    jump = j;
  endtask
  task automatic t_length;
    logic [15:0] rows [5];
    int q;
    int t2;
    rows = '{16'h0001, 16'h0530, 16'h0BFF, 16'h0CC9, 16'h008A};
    foreach (rows[i]) begin
      cfg(rows[i][15:10], rows[i][9:7], rows[i][6:4], rows[i][3:1], rows[i][0], 2'h0);
      q = 2 * (int'(rows[i][15:10]) + 1);
      t2 = rows[i][0] ? int'(rows[i][3:1]) + 1 : int'(rows[i][6:4]) + 1;
      if (t2 < 2)
        t2 = 2;
      wait_on(0, n);
      wait_on(0, n);
      wait_on(1, n);
      check(16'(n), 16'((3 + int'(rows[i][9:7]) + int'(rows[i][6:4])) * q));
      check(16'(segment), 16'(SEG_PH2));
      wait_on(0, n);
      check(16'(n), 16'(t2 * q));
    end
  endtask
  task automatic t_hard;
    cfg(6'h00, 3'h0, 3'h3, 3'h0, 1'b0, 2'h3);
    idle = 1'b1;
    wait_on(0, n);
    wait_on(1, n);
    other_dom = 1'b1;
    wait_on(2, n);
    check(16'(n), 16'h0003);
    check(16'({bit_start, segment}), 16'({1'b1, SEG_SYNC}));
    wait_on(1, n);
    check(16'(n), 16'h000C);
    check(16'(rx_bit), 16'h0000);
    other_dom = 1'b0;
    count_on(4, 30, n);
    check(16'(n), 16'h0000);
  endtask
  task automatic t_vote;
    cfg(6'h03, 3'h1, 3'h3, 3'h0, 1'b0, 2'h0);
    idle = 1'b0;
    other_dom = 1'b1;
    wait_on(1, n);
    wait_on(1, n);
    other_dom = 1'b0;
    for (int s = 0; s < 2; s++) begin
      samp_sel = s[0];
      repeat (83) @(posedge clk);
      #1;
      other_dom = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      other_dom = 1'b0;
      wait_on(1, n);
      check(16'(n), 16'h0002);
      check(16'(rx_bit), 16'(s));
    end
  endtask
  task automatic t_frames;
    cfg(6'h00, 3'h1, 3'h3, 3'h0, 1'b0, 2'h3);
    for (int d = 0; d < 2; d++) begin
      tx_dom = d[0];
      repeat (40) @(posedge clk);
      wait_on(1, n);
      start = 1'b1;
      @(posedge clk);
      #1;
      start = 1'b0;
      count_on(3, 212, n);
      check(16'(n), d ? 16'h0001 : 16'h0004);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1;
    check(16'({rx_bit, segment, pulses[3:0]}), 16'({1'b1, SEG_SYNC, 4'h0}));
    reset_n = 1'b1;
    t_length();
    t_hard();
    t_vote();
    t_frames();
    tally_and_finish();
  end
endmodule
`default_nettype wire
